// >>> limiter_pkg.sv
// Constants for the sensor drift and output limiter block.
// Assumes currents in microamps, temperatures signed 16-bit, times in tenths of seconds.
package limiter_pkg;
  // Register byte addresses
  localparam logic [5:0] A_CTRL    = 6'h00;
  localparam logic [5:0] A_DLIM    = 6'h04;
  localparam logic [5:0] A_DDAMP   = 6'h08;
  localparam logic [5:0] A_LRP     = 6'h0c;
  localparam logic [5:0] A_URP     = 6'h10;
  localparam logic [5:0] A_PDAMP   = 6'h14;
  localparam logic [5:0] A_LOALM   = 6'h18;
  localparam logic [5:0] A_HIALM   = 6'h1c;
  localparam logic [5:0] A_LOSAT   = 6'h20;
  localparam logic [5:0] A_HISAT   = 6'h24;
  localparam logic [5:0] A_STAT    = 6'h28;
  localparam logic [5:0] A_CODE    = 6'h2c;
  // Control bit positions
  localparam int B_DEN   = 0;
  localparam int B_DALM  = 1;
  localparam int B_FOEN  = 2;
  localparam int B_SAFE  = 3;
  localparam int B_PRE   = 4;
  localparam int B_PSEL  = 5;
  // Limits in microamps and tenths of seconds
  localparam logic [15:0] CODE_LO    = 16'h0fa0;
  localparam logic [15:0] CODE_SPAN  = 16'h3e80;
  localparam logic [15:0] LOALM_MIN  = 16'h0dac;
  localparam logic [15:0] LOALM_MAX  = 16'h0ea6;
  localparam logic [15:0] HIALM_MIN  = 16'h5208;
  localparam logic [15:0] HIALM_MAX  = 16'h59d8;
  localparam logic [15:0] SAT_GAP    = 16'h0064;
  localparam logic [15:0] LOSAT_MAX  = 16'h0f3c;
  localparam logic [15:0] HISAT_MIN  = 16'h5014;
  localparam logic [15:0] SAFE_MIN   = 16'h0e74;
  localparam logic [15:0] SAFE_MAX   = 16'h51a4;
  localparam logic [15:0] DAMP_MAX   = 16'h0140;
  localparam logic [15:0] PDAMP_RST  = 16'h0032;
  localparam logic [15:0] SAMPLE_TENTHS = 16'h0001;
  // Preset sets: standard, then NAMUR-compliant
  localparam logic [15:0] STD_LOALM  = 16'h0ea6;
  localparam logic [15:0] STD_HIALM  = 16'h54f6;
  localparam logic [15:0] STD_LOSAT  = 16'h0f3c;
  localparam logic [15:0] STD_HISAT  = 16'h5140;
  localparam logic [15:0] NAM_LOALM  = 16'h0e10;
  localparam logic [15:0] NAM_HIALM  = 16'h5208;
  localparam logic [15:0] NAM_LOSAT  = 16'h0e74;
  localparam logic [15:0] NAM_HISAT  = 16'h5014;
endpackage : limiter_pkg

// >>> drift_output_limiter.sv
// Dual-sensor drift check, range scaling, damping, saturation and alarm drive.
// Assumes sensor values and fail flags come from same-clock logic; fm_switch is a pin.
`timescale 1ns/1ps

// Function
// - With drift check on, flag warning when sensor difference exceeds limit.
// - Option lets drift also force loop output to alarm.
// - Warning-only mode sets status flag, leaves loop output alone.
// - Drift damping time accepted only from zero to 32 seconds.
// - Failover and drift alarm work together; after failover drift still compares both sensors and can force alarm.
// - Lower range point maps to 4 mA, upper to 20 mA.
// - Range points change only output scaling, not measured temperature.
// - Output smoothing time resets to 5.0 s, accepts zero to 32 s.
// - Smoothing time zero bypasses the filter.
// - Smoothing is first order, 63 percent after one time constant.
// - Low alarm current accepted only from 3.50 to 3.75 mA.
// - High alarm current accepted only from 21.0 to 23.0 mA.
// - Standard low saturation from low alarm plus 0.1 to 3.9 mA.
// - Safety variant saturation limited to 3.7 through 20.9 mA.
// - High saturation from 20.5 mA to high alarm minus 0.1.
// - Preset command loads standard or NAMUR alarm and saturation set.
// - Failure-mode switch picks high or low alarm level.
// - Once on second sensor, stay until failover re-enabled or reset.
module drift_output_limiter (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        sample_stb,
  input  wire logic [15:0] s1_val,
  input  wire logic [15:0] s2_val,
  input  wire logic        s1_fail,
  input  wire logic        s2_fail,
  input  wire logic        fm_switch,
  output logic      [15:0] loop_code,
  output logic             in_alarm,
  output logic             drift_warn
);
  logic        [5:0]  ctrl_r;
  logic        [15:0] dlim_r, ddamp_r, lrp_r, urp_r, pdamp_r;
  logic        [15:0] loalm_r, hialm_r, losat_r, hisat_r;
  logic               reject_r, on_second_r, fm_meta_r, fm_r;
  logic signed [31:0] pv_y_r, dd_y_r;
  logic        [31:0] rd_nxt;

  function automatic logic [16:0] alpha_of(input logic [15:0] tau);
    if (tau == 16'h0000) alpha_of = 17'h10000;
    else alpha_of = 17'(({16'h0, limiter_pkg::SAMPLE_TENTHS} << 16) / {16'h0, tau});
  endfunction : alpha_of

  // First-order step toward x, state in Q16
  function automatic logic signed [31:0] smooth(input logic signed [31:0] y,
      input logic signed [15:0] x, input logic [16:0] a);
    logic signed [33:0] d;
    logic signed [51:0] p;
    d = {{2{x[15]}}, x, 16'h0} - {{2{y[31]}}, y};
    p = d * $signed({1'b0, a});
    smooth = y + p[47:16];
  endfunction : smooth

  function automatic logic in_rng(input logic [15:0] v, lo, hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  // Bus decode
  wire        req    = read | write;
  wire        wr_go  = write & ~waitrequest;
  wire [15:0] wd     = writedata[15:0];
  wire        safe   = ctrl_r[limiter_pkg::B_SAFE];
  wire ok_dd  = wd <= limiter_pkg::DAMP_MAX;
  wire ok_la  = in_rng(wd, limiter_pkg::LOALM_MIN, limiter_pkg::LOALM_MAX);
  wire ok_ha  = in_rng(wd, limiter_pkg::HIALM_MIN, limiter_pkg::HIALM_MAX);
  wire ok_ls  = in_rng(wd, loalm_r + limiter_pkg::SAT_GAP, limiter_pkg::LOSAT_MAX)
              && (!safe || wd >= limiter_pkg::SAFE_MIN);
  wire ok_hs  = in_rng(wd, limiter_pkg::HISAT_MIN, hialm_r - limiter_pkg::SAT_GAP)
              && (!safe || wd <= limiter_pkg::SAFE_MAX);
  wire chk_wr = wr_go && (address == limiter_pkg::A_DDAMP || address == limiter_pkg::A_PDAMP
              || address == limiter_pkg::A_LOALM || address == limiter_pkg::A_HIALM
              || address == limiter_pkg::A_LOSAT || address == limiter_pkg::A_HISAT);
  wire ok_wr  = (address == limiter_pkg::A_DDAMP || address == limiter_pkg::A_PDAMP) ? ok_dd :
                address == limiter_pkg::A_LOALM ? ok_la :
                address == limiter_pkg::A_HIALM ? ok_ha :
                address == limiter_pkg::A_LOSAT ? ok_ls : ok_hs;
  wire ctrl_wr = wr_go && address == limiter_pkg::A_CTRL;
  wire rearm   = ctrl_wr && writedata[limiter_pkg::B_FOEN];
  wire preset  = ctrl_wr && writedata[limiter_pkg::B_PRE];
  wire psel    = writedata[limiter_pkg::B_PSEL];

  // Source selection and failover
  wire fo_en    = ctrl_r[limiter_pkg::B_FOEN];
  wire sel2     = on_second_r || (fo_en && s1_fail);
  wire pv_fail  = sel2 ? s2_fail : s1_fail;
  wire [15:0] pv_in = sel2 ? s2_val : s1_val;

  // Sensor difference, saturated to positive 16-bit
  wire signed [16:0] dif  = $signed({s1_val[15], s1_val}) - $signed({s2_val[15], s2_val});
  wire        [16:0] adif = dif[16] ? 17'(-dif) : 17'(dif);
  wire        [15:0] dabs = adif > 17'h07fff ? 16'h7fff : adif[15:0];
  wire        [15:0] dd_now = dd_y_r[31:16];
  wire warn_nxt  = ctrl_r[limiter_pkg::B_DEN] && (dd_now > dlim_r);
  wire drift_alm = warn_nxt && ctrl_r[limiter_pkg::B_DALM];
  wire alarm     = pv_fail || drift_alm;
  wire [15:0] alm_lvl = fm_r ? hialm_r : loalm_r;

  // Range scaling of the smoothed primary value
  wire signed [15:0] pv_now = pv_y_r[31:16];
  wire signed [16:0] span = $signed({urp_r[15], urp_r}) - $signed({lrp_r[15], lrp_r});
  wire signed [16:0] ofs  = $signed({pv_now[15], pv_now}) - $signed({lrp_r[15], lrp_r});
  wire signed [47:0] num  = 48'(ofs) * $signed({32'h0, limiter_pkg::CODE_SPAN});
  wire signed [47:0] scl  = (span > 17'sh0) ? ($signed({32'h0, limiter_pkg::CODE_LO})
                          + num / 48'(span)) : $signed({32'h0, limiter_pkg::CODE_LO});
  wire signed [47:0] lo48 = $signed({32'h0, losat_r});
  wire signed [47:0] hi48 = $signed({32'h0, hisat_r});
  wire [15:0] clamped = scl < lo48 ? losat_r : scl > hi48 ? hisat_r : scl[15:0];

  always_comb begin
    unique case (address)
      limiter_pkg::A_CTRL:  rd_nxt = {26'h0, ctrl_r};
      limiter_pkg::A_DLIM:  rd_nxt = {16'h0, dlim_r};
      limiter_pkg::A_DDAMP: rd_nxt = {16'h0, ddamp_r};
      limiter_pkg::A_LRP:   rd_nxt = {16'h0, lrp_r};
      limiter_pkg::A_URP:   rd_nxt = {16'h0, urp_r};
      limiter_pkg::A_PDAMP: rd_nxt = {16'h0, pdamp_r};
      limiter_pkg::A_LOALM: rd_nxt = {16'h0, loalm_r};
      limiter_pkg::A_HIALM: rd_nxt = {16'h0, hialm_r};
      limiter_pkg::A_LOSAT: rd_nxt = {16'h0, losat_r};
      limiter_pkg::A_HISAT: rd_nxt = {16'h0, hisat_r};
      limiter_pkg::A_STAT:  rd_nxt = {25'h0, fm_r, reject_r, in_alarm, on_second_r,
                                      s2_fail, s1_fail, drift_warn};
      limiter_pkg::A_CODE:  rd_nxt = {16'h0, loop_code};
      default:              rd_nxt = 32'h0;
    endcase
  end

  // Bus handshake: answer one cycle after the request appears
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      waitrequest <= !(req && waitrequest);
      if (req && waitrequest) readdata <= rd_nxt;
    end
  end

  // Configuration registers with range checks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r   <= 6'h0;
      dlim_r   <= 16'h0;
      ddamp_r  <= 16'h0;
      lrp_r    <= 16'h0;
      urp_r    <= 16'h0;
      pdamp_r  <= limiter_pkg::PDAMP_RST;
      loalm_r  <= limiter_pkg::STD_LOALM;
      hialm_r  <= limiter_pkg::STD_HIALM;
      losat_r  <= limiter_pkg::STD_LOSAT;
      hisat_r  <= limiter_pkg::STD_HISAT;
      reject_r <= 1'b0;
    end else begin
      if (chk_wr) reject_r <= !ok_wr;
      if (ctrl_wr) ctrl_r <= {1'b0, 1'b0, writedata[3:0]};
      if (preset) begin
        loalm_r <= psel ? limiter_pkg::NAM_LOALM : limiter_pkg::STD_LOALM;
        hialm_r <= psel ? limiter_pkg::NAM_HIALM : limiter_pkg::STD_HIALM;
        losat_r <= psel ? limiter_pkg::NAM_LOSAT : limiter_pkg::STD_LOSAT;
        hisat_r <= psel ? limiter_pkg::NAM_HISAT : limiter_pkg::STD_HISAT;
      end else if (wr_go) begin
        unique case (address)
          limiter_pkg::A_DLIM:  dlim_r <= wd;
          limiter_pkg::A_DDAMP: if (ok_dd) ddamp_r <= wd;
          limiter_pkg::A_LRP:   lrp_r <= wd;
          limiter_pkg::A_URP:   urp_r <= wd;
          limiter_pkg::A_PDAMP: if (ok_dd) pdamp_r <= wd;
          limiter_pkg::A_LOALM: if (ok_la) loalm_r <= wd;
          limiter_pkg::A_HIALM: if (ok_ha) hialm_r <= wd;
          limiter_pkg::A_LOSAT: if (ok_ls) losat_r <= wd;
          limiter_pkg::A_HISAT: if (ok_hs) hisat_r <= wd;
          default: ;
        endcase
      end
    end
  end

  // Failover latch, filters and loop output
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_second_r <= 1'b0;
      fm_meta_r   <= 1'b0;
      fm_r        <= 1'b0;
      pv_y_r      <= 32'sh0;
      dd_y_r      <= 32'sh0;
      loop_code   <= limiter_pkg::CODE_LO;
      in_alarm    <= 1'b0;
      drift_warn  <= 1'b0;
    end else begin
      on_second_r <= (fo_en && s1_fail) || (on_second_r && !rearm);
      fm_meta_r   <= fm_switch;
      fm_r        <= fm_meta_r;
      if (sample_stb) begin
        pv_y_r <= smooth(pv_y_r, pv_in, alpha_of(pdamp_r));
        dd_y_r <= smooth(dd_y_r, dabs, alpha_of(ddamp_r));
      end
      drift_warn <= warn_nxt;
      in_alarm   <= alarm;
      loop_code  <= alarm ? alm_lvl : clamped;
    end
  end

  // Checks
  sequence req_open;
    req && waitrequest;
  endsequence
  sequence drift_seen;
    ctrl_r[limiter_pkg::B_DEN] && (dd_now > dlim_r);
  endsequence

  bus_answer_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    req_open |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  drift_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    drift_seen |=> drift_warn)
    else $error("drift warning not raised");
  drift_alarm_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    drift_seen and ctrl_r[limiter_pkg::B_DALM] |=> in_alarm && loop_code == $past(alm_lvl))
    else $error("drift alarm not driven");
  warn_only_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    drift_seen and !ctrl_r[limiter_pkg::B_DALM] and !pv_fail |=> !in_alarm)
    else $error("warning-only disturbed output");
  damp_range_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    ddamp_r <= limiter_pkg::DAMP_MAX && pdamp_r <= limiter_pkg::DAMP_MAX)
    else $error("damping out of range");
  failover_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    on_second_r && !rearm |=> on_second_r)
    else $error("returned to first sensor");
  failover_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fo_en && s1_fail && !s2_fail && !drift_alm |=> on_second_r && !in_alarm)
    else $error("failover did not switch");
  bypass_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_stb && pdamp_r == 16'h0 |=> pv_now == $past(pv_in))
    else $error("zero damping not bypassed");
  alarm_cfg_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    in_rng(loalm_r, limiter_pkg::LOALM_MIN, limiter_pkg::LOALM_MAX)
    && in_rng(hialm_r, limiter_pkg::HIALM_MIN, limiter_pkg::HIALM_MAX))
    else $error("alarm level out of range");
  sat_clamp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !alarm |=> loop_code >= $past(losat_r) && loop_code <= $past(hisat_r))
    else $error("output outside saturation");
  alarm_prio_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    alarm && fm_r |=> loop_code == $past(hialm_r))
    else $error("alarm level not selected");
  switch_low_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    alarm && !fm_r |=> loop_code == $past(loalm_r))
    else $error("low alarm not selected");

  // Range, preset and output checks
  lo_alarm_take_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_go && address == limiter_pkg::A_LOALM && wd >= limiter_pkg::LOALM_MIN
    && wd <= limiter_pkg::LOALM_MAX |=> loalm_r == $past(wd))
    else $error("low alarm write lost");
  hi_alarm_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_go && address == limiter_pkg::A_HIALM
    && (wd < limiter_pkg::HIALM_MIN || wd > limiter_pkg::HIALM_MAX) |=> $stable(hialm_r))
    else $error("bad high alarm accepted");
  lo_sat_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_go && address == limiter_pkg::A_LOSAT
    && (wd < loalm_r + limiter_pkg::SAT_GAP || wd > limiter_pkg::LOSAT_MAX)
    |=> $stable(losat_r))
    else $error("bad low saturation accepted");
  hi_sat_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_go && address == limiter_pkg::A_HISAT
    && (wd < limiter_pkg::HISAT_MIN || wd > hialm_r - limiter_pkg::SAT_GAP)
    |=> $stable(hisat_r))
    else $error("bad high saturation accepted");
  safe_sat_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_go && safe && address == limiter_pkg::A_HISAT && wd > limiter_pkg::SAFE_MAX
    |=> $stable(hisat_r))
    else $error("safety saturation limit broken");
  preset_namur_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    preset && psel |=> loalm_r == limiter_pkg::NAM_LOALM && hialm_r == limiter_pkg::NAM_HIALM
    && losat_r == limiter_pkg::NAM_LOSAT && hisat_r == limiter_pkg::NAM_HISAT)
    else $error("second preset set not loaded");
  preset_std_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    preset && !psel |=> loalm_r == limiter_pkg::STD_LOALM && hialm_r == limiter_pkg::STD_HIALM
    && losat_r == limiter_pkg::STD_LOSAT && hisat_r == limiter_pkg::STD_HISAT)
    else $error("standard preset set not loaded");
  scale_bottom_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !alarm && span > 17'sh0 && pv_now == $signed(lrp_r) && losat_r <= limiter_pkg::CODE_LO
    |=> loop_code == limiter_pkg::CODE_LO)
    else $error("lower range point not at bottom");
  warn_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !ctrl_r[limiter_pkg::B_DEN] |=> !drift_warn)
    else $error("drift warning while disabled");
  smooth_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_stb && pdamp_r != 16'h0 && $signed(pv_in) >= pv_now
    |=> pv_now <= $signed($past(pv_in)))
    else $error("smoothing overshoots input");
  failover_out_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    on_second_r && !s2_fail && !drift_alm |=> !in_alarm)
    else $error("good second sensor in alarm");
  bus_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(req && waitrequest) |=> waitrequest)
    else $error("waitrequest low without request");
  read_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(req && waitrequest) |=> $stable(readdata))
    else $error("read data moved without request");

endmodule : drift_output_limiter

// >>> loop_host_model.sv
// Register bus master standing in for the configuring host.
// Assumes the block lowers waitrequest for one cycle per request.
`timescale 1ns/1ps
module loop_host_model (
  input  wire logic        core_clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata
);
  initial begin
    address   = 6'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
  end
  // Write held until waitrequest is seen low
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    address   <= a;
    writedata <= {16'h0000, d};
    write     <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr
  // Read data taken at the waitrequest-low edge
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : rd
endmodule : loop_host_model

// >>> drift_output_limiter_test.sv
// Self-checking bench for the drift and output limiter.
// Assumes the host model carries all register traffic.
`timescale 1ns/1ps
module drift_output_limiter_test;
  logic        core_clk, arst_n, sample_stb, s1_fail, s2_fail, fm_switch;
  logic        read, write, waitrequest, in_alarm, drift_warn;
  logic [15:0] s1_val, s2_val, loop_code;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, st;
  int          err_count, cmp_count;
  logic [5:0]  ta [16] = '{limiter_pkg::A_DDAMP, limiter_pkg::A_PDAMP, limiter_pkg::A_LOALM,
    limiter_pkg::A_LOALM, limiter_pkg::A_HIALM, limiter_pkg::A_HIALM, limiter_pkg::A_LOSAT,
    limiter_pkg::A_LOSAT, limiter_pkg::A_HISAT, limiter_pkg::A_HISAT, limiter_pkg::A_DDAMP,
    limiter_pkg::A_LOALM, limiter_pkg::A_HIALM, limiter_pkg::A_LOSAT, limiter_pkg::A_HISAT,
    limiter_pkg::A_DDAMP};
  logic [15:0] tv [16] = '{16'h0141, 16'h0141, 16'h0dab, 16'h0ea7, 16'h5207, 16'h59d9,
    16'h0f09, 16'h0f3d, 16'h5013, 16'h5493, 16'h0140, 16'h0dac, 16'h59d8, 16'h0e10,
    16'h5974, 16'h0000};
  logic [15:0] te [16] = '{16'h0000, 16'h0032, 16'h0ea6, 16'h0ea6, 16'h54f6, 16'h54f6,
    16'h0f3c, 16'h0f3c, 16'h5140, 16'h5140, 16'h0140, 16'h0dac, 16'h59d8, 16'h0e10,
    16'h5974, 16'h0000};

  drift_output_limiter i_dut (.core_clk(core_clk), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sample_stb(sample_stb), .s1_val(s1_val), .s2_val(s2_val),
    .s1_fail(s1_fail), .s2_fail(s2_fail), .fm_switch(fm_switch), .loop_code(loop_code),
    .in_alarm(in_alarm), .drift_warn(drift_warn));
  loop_host_model i_host (.core_clk(core_clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    logic [31:0] v;
    i_host.rd(a, v);
    chk(v, {16'h0000, e});
  endtask : rchk
  // One sensor sample, then wait until the outputs reflect it
  task automatic samp(input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk);
    s1_val     <= a;
    s2_val     <= b;
    sample_stb <= 1'b1;
    @(posedge core_clk);
    sample_stb <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : samp

  initial begin
    #200us;
    err_count++;
    complete_run();
  end

  initial begin
    {arst_n, sample_stb, s1_fail, s2_fail} = 4'h0;
    {s1_val, s2_val} = 32'h0000_0000;
    fm_switch = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rchk(limiter_pkg::A_PDAMP, 16'h0032);
    for (int i = 0; i < 16; i++) begin
      i_host.wr(ta[i], tv[i]);
      rchk(ta[i], te[i]);
      i_host.rd(limiter_pkg::A_STAT, st);
      chk({31'h0, st[5]}, {31'h0, tv[i] !== te[i]});
    end
    i_host.wr(limiter_pkg::A_CTRL, 16'h0030);
    rchk(limiter_pkg::A_LOALM, 16'h0e10);
    rchk(limiter_pkg::A_HISAT, 16'h5014);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0018);
    rchk(limiter_pkg::A_LOSAT, 16'h0f3c);
    i_host.wr(limiter_pkg::A_HISAT, 16'h51d6);
    rchk(limiter_pkg::A_HISAT, 16'h5140);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0000);
    i_host.wr(limiter_pkg::A_PDAMP, 16'h0000);
    i_host.wr(limiter_pkg::A_URP, 16'h03e8);
    samp(16'h01f4, 16'h01f4);
    chk(loop_code, 16'h2ee0);
    rchk(limiter_pkg::A_CODE, 16'h2ee0);
    samp(16'h07d0, 16'h07d0);
    chk(loop_code, 16'h5140);
    samp(16'hff9c, 16'hff9c);
    chk(loop_code, 16'h0f3c);
    i_host.wr(limiter_pkg::A_URP, 16'h07d0);
    samp(16'h03e8, 16'h03e8);
    chk(loop_code, 16'h2ee0);
    i_host.wr(limiter_pkg::A_DLIM, 16'h000a);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0001);
    samp(16'h03e8, 16'h03fc);
    chk({drift_warn, in_alarm, loop_code}, {2'b10, 16'h2ee0});
    samp(16'h03e8, 16'h03ed);
    chk({drift_warn, in_alarm}, 2'b00);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0003);
    samp(16'h03e8, 16'h03fc);
    chk({in_alarm, loop_code}, {1'b1, 16'h54f6});
    @(posedge core_clk);
    fm_switch <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk(loop_code, 16'h0ea6);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0005);
    s1_fail <= 1'b1;
    samp(16'h0000, 16'h03e8);
    chk({drift_warn, in_alarm, loop_code}, {2'b10, 16'h2ee0});
    i_host.wr(limiter_pkg::A_CTRL, 16'h0007);
    samp(16'h0000, 16'h03e8);
    chk({in_alarm, loop_code}, {1'b1, 16'h0ea6});
    i_host.wr(limiter_pkg::A_CTRL, 16'h0005);
    s1_fail <= 1'b0;
    samp(16'h0000, 16'h03e8);
    chk(loop_code, 16'h2ee0);
    i_host.rd(limiter_pkg::A_STAT, st);
    chk({31'h0, st[3]}, 32'h1);
    i_host.wr(limiter_pkg::A_CTRL, 16'h0004);
    samp(16'h0000, 16'h03e8);
    chk({in_alarm, loop_code}, {1'b0, 16'h0fa0});
    i_host.wr(limiter_pkg::A_PDAMP, 16'h000a);
    repeat (10) samp(16'h03e8, 16'h03e8);
    chk({31'h0, loop_code >= 16'h2260 && loop_code <= 16'h24b8}, 32'h1);
    complete_run();
  end
endmodule : drift_output_limiter_test
